//--- common/clk_cfg_regs.svh
`ifndef CLK_CFG_REGS_SVH
`define CLK_CFG_REGS_SVH
// ************************************************************
// register map and fields
// ************************************************************
`define CFG_BYTE0_OFS      5'h00
`define CFG_BYTE1_OFS      5'h01
`define CFG_BYTE0_RESET    8'h00
`define CFG_BYTE1_RESET    8'h0F
`define BYTE_CMD_PREFIX    3'h4
`define SLAVE_ADDR7        7'h69
`define FLD_OVERRIDE       3
`define FLD_CS_FREE        0
`define FLD_EN_CS          3
`define FLD_EN_ONE         2
`define FLD_EN_ZERO        1
// ************************************************************
// link timing: serial clock half period in ref clock cycles
// ************************************************************
`define SCL_FREQ_KHZ       100
`define REF_FREQ_KHZ       200000
`define SCL_HALF_CYCLES    (`REF_FREQ_KHZ / (2 * `SCL_FREQ_KHZ))
`endif

//--- common/clk_cfg_pkg.sv
package clk_cfg_pkg;
   typedef enum logic [3:0] {
      S_IDLE  = 4'h0,
      S_ADDR  = 4'h1,
      S_AACK  = 4'h2,
      S_CMD   = 4'h3,
      S_CACK  = 4'h4,
      S_WDATA = 4'h5,
      S_WACK  = 4'h6,
      S_RDATA = 4'h7,
      S_MACK  = 4'h8,
      S_IGN   = 4'h9
   } dev_state_e;
   typedef enum logic [3:0] {
      H_IDLE  = 4'h0,
      H_START = 4'h1,
      H_BITLO = 4'h2,
      H_BITHI = 4'h3,
      H_RSTA  = 4'h4,
      H_RSTB  = 4'h5,
      H_STOPA = 4'h6,
      H_STOPB = 4'h7,
      H_STOPC = 4'h8
   } host_state_e;
   typedef enum logic [2:0] {
      SPREAD_OFF   = 3'h0,
      SPREAD_C025  = 3'h4,
      SPREAD_D050  = 3'h5,
      SPREAD_C050  = 3'h6,
      SPREAD_C038  = 3'h7
   } spread_mode_e;
endpackage

//--- common/cfg_link_if.sv
`timescale 1ns/1ps
// open-drain two-wire link; a low driver wins, otherwise pulled high
interface cfg_link_if;
   logic scl_host_oe;
   logic sda_host_oe;
   logic sda_dev_oe;
   wire  scl;
   wire  sda;
   assign scl = ~scl_host_oe;
   assign sda = ~(sda_host_oe | sda_dev_oe);
   modport dev  (input scl, input sda, output sda_dev_oe);
   modport host (output scl_host_oe, output sda_host_oe, input scl, input sda);
endinterface

//--- hw/clk_cfg_dev.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "clk_cfg_regs.svh"
module clk_cfg_dev
   import clk_cfg_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   // serial link
   cfg_link_if.dev         link,
   // strap and stop inputs
   input  wire logic [4:0] strap_freq_pins_in,
   input  wire logic       cpu_stop_n_in,
   // clock control outputs
   output logic [4:0]      freq_select_out,
   output logic [2:0]      spread_mode_out,
   output logic            spread_reserved_out,
   output logic            chipset_cpu_pair_en_out,
   output logic            cpu_pair_one_en_out,
   output logic            cpu_pair_zero_en_out,
   output logic            chipset_pair_free_en_out
);
   // ************************************************************
   // link sampling and edge detection
   // ************************************************************
   // protocol state; the link is far slower than the ref clock
   logic       scl_d_reg;                    // last sampled serial clock
   logic       sda_d_reg;                    // last sampled serial data
   logic [7:0] freq_select_cfg_reg;          // configuration byte 0
   logic [7:0] spread_and_cpu_clk_cfg_reg;   // configuration byte 1
   logic [7:0] shift_reg;                    // byte in or out, msb first
   logic [3:0] bit_cnt_reg;
   logic [4:0] index_reg;                    // byte index from the command
   logic       is_read_reg;
   logic       sda_oe_reg;
   dev_state_e state_reg;

   // edges show one ref clock late, which the slow link never notices
   wire scl_rise   = link.scl & ~scl_d_reg;
   wire scl_fall   = ~link.scl & scl_d_reg;
   // a start or stop is an sda edge while scl stays high
   wire start_cond = link.scl & scl_d_reg & sda_d_reg & ~link.sda;
   wire stop_cond  = link.scl & scl_d_reg & ~sda_d_reg & link.sda;
   wire [7:0] shift_next = {shift_reg[6:0], link.sda};
   wire byte_done  = scl_rise & (bit_cnt_reg == 4'h7);

   // index decode for the read path; the write path decodes index_reg in its own case
   function automatic logic [7:0] read_cfg(input logic [4:0] idx,
                                           input logic [7:0] b0,
                                           input logic [7:0] b1);
      case (idx)
         `CFG_BYTE0_OFS: read_cfg = b0;
         `CFG_BYTE1_OFS: read_cfg = b1;
         // unmapped indexes read back as zero
         default:        read_cfg = 8'h00;
      endcase
   endfunction

   // ************************************************************
   // frame decode
   // ************************************************************
   // the direction bit is left out, so the read restart hits as well
   wire addr_hit  = (shift_next[7:1] == `SLAVE_ADDR7);
   wire byte_cmd  = (shift_next[7:5] == `BYTE_CMD_PREFIX);
   // index_reg survives the restart, so a read returns the commanded byte
   wire [7:0] rd_byte = read_cfg(index_reg, freq_select_cfg_reg,
                                 spread_and_cpu_clk_cfg_reg);

   // ************************************************************
   // protocol engine
   // ************************************************************
   // block transfers are not supported; a block command is left unacked
   // sda only moves while scl is low, so acks never fake a start or stop
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scl_d_reg   <= 1'b1;
         sda_d_reg   <= 1'b1;
         state_reg   <= S_IDLE;
         shift_reg   <= 8'h00;
         bit_cnt_reg <= 4'h0;
         index_reg   <= 5'h00;
         is_read_reg <= 1'b0;
         sda_oe_reg  <= 1'b0;
         // defaults make the part usable with no serial access at all
         freq_select_cfg_reg        <= `CFG_BYTE0_RESET;
         spread_and_cpu_clk_cfg_reg <= `CFG_BYTE1_RESET;
      end else begin
         scl_d_reg <= link.scl;
         sda_d_reg <= link.sda;
         if (start_cond) begin
            state_reg   <= S_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
         end else if (stop_cond) begin
            state_reg  <= S_IDLE;
            sda_oe_reg <= 1'b0;
         end else begin
            case (state_reg)
               S_ADDR, S_CMD, S_WDATA: begin
                  if (scl_rise) begin
                     shift_reg   <= shift_next;
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  if (byte_done) begin
                     bit_cnt_reg <= 4'h0;
                     if (state_reg == S_ADDR) begin
                        is_read_reg <= shift_next[0];
                        state_reg   <= addr_hit ? S_AACK : S_IGN;
                     end else if (state_reg == S_CMD) begin
                        index_reg <= shift_next[4:0];
                        state_reg <= byte_cmd ? S_CACK : S_IGN;
                     end else begin
                        case (index_reg)
                           `CFG_BYTE0_OFS: freq_select_cfg_reg <= shift_next;
                           `CFG_BYTE1_OFS: spread_and_cpu_clk_cfg_reg <= shift_next;
                           // bytes 2 and up are not stored, yet the write is acked
                           default: ;
                        endcase
                        state_reg <= S_WACK;
                     end
                  end
               end
               // first fall after the byte pulls sda low, the second lets go or, after a read address, drives read bit 7
               S_AACK, S_CACK, S_WACK: begin
                  if (scl_fall && !sda_oe_reg) begin
                     sda_oe_reg <= 1'b1;
                  end else if (scl_fall) begin
                     sda_oe_reg <= 1'b0;
                     if (state_reg == S_AACK && is_read_reg) begin
                        state_reg  <= S_RDATA;
                        shift_reg  <= rd_byte;
                        sda_oe_reg <= ~rd_byte[7];
                     end else if (state_reg == S_AACK) begin
                        state_reg <= S_CMD;
                     end else if (state_reg == S_CACK) begin
                        state_reg <= S_WDATA;
                     end else begin
                        state_reg <= S_IGN;
                     end
                  end
               end
               // bit 7 went out with the ack release, so eight falls end the byte
               S_RDATA: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     if (bit_cnt_reg == 4'h7) begin
                        sda_oe_reg <= 1'b0;
                        state_reg  <= S_MACK;
                     end else begin
                        shift_reg  <= {shift_reg[6:0], 1'b0};
                        sda_oe_reg <= ~shift_reg[6];
                     end
                  end
               end
               // the host's closing bit is not checked; either level ends the read
               S_MACK: begin
                  if (scl_rise) begin
                     state_reg <= S_IGN;
                  end
               end
               // wrong address, block command or finished transfer: stay silent until a start or stop
               S_IGN: state_reg <= S_IGN;
               default: state_reg <= S_IDLE;
            endcase
         end
      end
   end

   // open drain: a high enable pulls the line low
   assign link.sda_dev_oe = sda_oe_reg;

   // ************************************************************
   // configuration decode to clock controls
   // ************************************************************
   // software select bits are scattered over byte 0; gather them msb first
   wire override = freq_select_cfg_reg[`FLD_OVERRIDE];
   wire [4:0] sw_freq = {freq_select_cfg_reg[2], freq_select_cfg_reg[1],
                         freq_select_cfg_reg[6], freq_select_cfg_reg[5],
                         freq_select_cfg_reg[4]};
   // reserved spread codes pass through and are flagged, not blocked
   wire [2:0] spread = spread_and_cpu_clk_cfg_reg[6:4];
   wire cs_free = spread_and_cpu_clk_cfg_reg[`FLD_CS_FREE];
   // next values of the clock controls; the flops below only copy them
   wire [4:0] freq_select_next     = override ? sw_freq : strap_freq_pins_in;
   wire       spread_reserved_next = (spread != 3'h0) & ~spread[2];
   // the free-run bit only matters while the stop input is held low
   wire       pair_free_next       = cs_free | cpu_stop_n_in;

   // outputs registered to keep glitches off the clock gates
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         freq_select_out          <= 5'h00;
         spread_mode_out          <= 3'h0;
         spread_reserved_out      <= 1'b0;
         chipset_cpu_pair_en_out  <= 1'b1;
         cpu_pair_one_en_out      <= 1'b1;
         cpu_pair_zero_en_out     <= 1'b1;
         chipset_pair_free_en_out <= 1'b1;
      end else begin
         freq_select_out <= freq_select_next;
         spread_mode_out <= spread;
         spread_reserved_out <= spread_reserved_next;
         chipset_cpu_pair_en_out <= spread_and_cpu_clk_cfg_reg[`FLD_EN_CS];
         cpu_pair_one_en_out     <= spread_and_cpu_clk_cfg_reg[`FLD_EN_ONE];
         cpu_pair_zero_en_out    <= spread_and_cpu_clk_cfg_reg[`FLD_EN_ZERO];
         chipset_pair_free_en_out <= pair_free_next;
      end
   end
endmodule

//--- hw/clk_cfg_host.sv
`timescale 1ns/1ps
`include "clk_cfg_regs.svh"
module clk_cfg_host
   import clk_cfg_pkg::*;
#(
   parameter int HALF = `SCL_HALF_CYCLES
)(
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   // software port
   input  wire logic [1:0] addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic [15:0]     rdata_out,
   // serial link
   cfg_link_if.host        link
);
   // ************************************************************
   // software registers: 0 command, 1 status, 2 read data
   // ************************************************************
   // command word: [15] read, [12:8] index, [7:0] write data
   logic        busy_reg, nack_reg, is_rd_reg, scl_oe_reg, sda_oe_reg;
   logic [7:0]  rdata_reg;
   logic [35:0] seq_reg;      // bits still to send, msb first
   logic [5:0]  nbits_reg;
   logic [5:0]  bit_idx_reg;
   logic [15:0] tmr_reg;
   logic        phase_rd_reg;
   host_state_e state_reg;

   wire tick = (tmr_reg == 16'h0);
   wire go   = wr_in & (addr_in == 2'h0) & ~busy_reg;
   wire [7:0] cmd_code = {`BYTE_CMD_PREFIX, wdata_in[12:8]};
   // ack slots sent as released (1); read data slots released too
   wire [35:0] wr_seq = {`SLAVE_ADDR7, 1'b0, 1'b1, cmd_code, 1'b1,
                         wdata_in[7:0], 1'b1, 9'h000};
   // last slot of a read is released, so the byte is closed with a nack
   wire [35:0] rd_seq = {`SLAVE_ADDR7, 1'b0, 1'b1, cmd_code, 1'b1,
                         `SLAVE_ADDR7, 1'b1, 1'b1, 8'hFF, 1'b1};
   // device ack slots: address, command, then data or read address
   wire ack_slot = (bit_idx_reg == 6'h08) | (bit_idx_reg == 6'h11) |
                   (bit_idx_reg == 6'h1A);
   wire rd_slot  = is_rd_reg & (bit_idx_reg >= 6'h1B) & (bit_idx_reg <= 6'h22);

   // ************************************************************
   // bit sequencer
   // ************************************************************
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= H_IDLE; busy_reg <= 1'b0; nack_reg <= 1'b0;
         is_rd_reg <= 1'b0; scl_oe_reg <= 1'b0; sda_oe_reg <= 1'b0;
         rdata_reg <= 8'h00; seq_reg <= 36'h0; nbits_reg <= 6'h0;
         bit_idx_reg <= 6'h0; tmr_reg <= 16'h0; phase_rd_reg <= 1'b0;
      end else begin
         tmr_reg <= tick ? 16'(HALF - 1) : tmr_reg - 16'h1;
         case (state_reg)
            H_IDLE: if (go) begin
               busy_reg <= 1'b1; nack_reg <= 1'b0; is_rd_reg <= wdata_in[15];
               seq_reg  <= wdata_in[15] ? rd_seq : wr_seq;
               nbits_reg <= wdata_in[15] ? 6'h24 : 6'h1B;
               bit_idx_reg <= 6'h0; phase_rd_reg <= 1'b0;
               tmr_reg <= 16'(HALF - 1); state_reg <= H_START;
            end
            H_START: if (tick) begin
               sda_oe_reg <= 1'b1; state_reg <= H_BITLO;
            end
            H_BITLO: if (tick) begin
               scl_oe_reg <= 1'b1;
               sda_oe_reg <= ~seq_reg[35];
               state_reg  <= H_BITHI;
            end
            H_BITHI: if (tick) begin
               if (scl_oe_reg) begin
                  scl_oe_reg <= 1'b0;
               end else begin
                  if (ack_slot && link.sda) nack_reg <= 1'b1;
                  if (rd_slot) rdata_reg <= {rdata_reg[6:0], link.sda};
                  seq_reg <= {seq_reg[34:0], 1'b0};
                  bit_idx_reg <= bit_idx_reg + 6'h1;
                  scl_oe_reg <= 1'b1;
                  if (bit_idx_reg + 6'h1 == nbits_reg) begin
                     sda_oe_reg <= 1'b1; state_reg <= H_STOPA;
                  end else if (is_rd_reg && bit_idx_reg == 6'h11) begin
                     sda_oe_reg <= 1'b0; state_reg <= H_RSTA;
                  end else begin
                     sda_oe_reg <= ~seq_reg[34]; state_reg <= H_BITHI;
                     scl_oe_reg <= 1'b1;
                  end
               end
            end
            H_RSTA: if (tick) begin
               scl_oe_reg <= 1'b0; state_reg <= H_RSTB;
            end
            H_RSTB: if (tick) begin
               sda_oe_reg <= 1'b1; state_reg <= H_BITLO;
            end
            H_STOPA: if (tick) begin
               scl_oe_reg <= 1'b0; state_reg <= H_STOPB;
            end
            H_STOPB: if (tick) begin
               sda_oe_reg <= 1'b0; state_reg <= H_STOPC;
            end
            H_STOPC: if (tick) begin
               busy_reg <= 1'b0; state_reg <= H_IDLE;
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) rdata_out <= 16'h0000;
      else if (rd_in) begin
         case (addr_in)
            2'h1:    rdata_out <= {14'h0000, nack_reg, busy_reg};
            2'h2:    rdata_out <= {8'h00, rdata_reg};
            default: rdata_out <= 16'h0000;
         endcase
      end
   end

   assign link.scl_host_oe = scl_oe_reg;
   assign link.sda_host_oe = sda_oe_reg;
endmodule

//--- dv/clk_cfg_link_checker.sv
`timescale 1ns/1ps
`include "clk_cfg_regs.svh"
// ************************************************************
// wire-level checks on the two-wire link
// ************************************************************
module clk_cfg_link_checker (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // link signals
   input wire logic scl_host_oe,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   logic       scl_q, sda_q, in_frame, restarted, rw;
   logic [3:0] pos;
   logic [2:0] byte_idx;
   logic [7:0] sh;
   // start and stop are the only sda edges allowed while scl is high
   wire start_c = scl && scl_q && sda_q && !sda;
   wire stop_c  = scl && scl_q && !sda_q && sda;
   wire rise_c  = scl && !scl_q;
   wire hi_c    = scl && scl_q;
   // frame tracker: bit position 1..9 and byte count since last start
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scl_q <= 1'b1; sda_q <= 1'b1; in_frame <= 1'b0; restarted <= 1'b0;
         rw <= 1'b0; pos <= 4'h0; byte_idx <= 3'h0; sh <= 8'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_c) begin
            pos <= 4'h0; byte_idx <= 3'h0; restarted <= in_frame; in_frame <= 1'b1;
         end else if (stop_c) begin
            in_frame <= 1'b0;
         end else if (rise_c) begin
            pos <= (pos == 4'h9) ? 4'h1 : pos + 4'h1;
            sh  <= {sh[6:0], sda};
            if (pos == 4'h9) byte_idx <= byte_idx + 3'h1;
            if (pos == 4'h7 && byte_idx == 3'h0) rw <= sda;
         end
      end
   end
   property p_addr_match; hi_c && pos == 4'h8 && byte_idx == 3'h0 |-> sh[7:1] == `SLAVE_ADDR7; endproperty
   a_addr_match: assert property (p_addr_match) else $error("wrong slave address");
   property p_write_first; hi_c && pos == 4'h8 && byte_idx == 3'h0 && !restarted |-> !sh[0]; endproperty
   a_write_first: assert property (p_write_first) else $error("first address not write");
   property p_read_again; hi_c && pos == 4'h8 && byte_idx == 3'h0 && restarted |-> sh[0]; endproperty
   a_read_again: assert property (p_read_again) else $error("restart address not read");
   property p_cmd_prefix; hi_c && pos == 4'h8 && byte_idx == 3'h1 && !rw |-> sh[7:5] == 3'h4; endproperty
   a_cmd_prefix: assert property (p_cmd_prefix) else $error("command prefix wrong");
   property p_dev_ack;
      hi_c && pos == 4'h9 && (byte_idx == 3'h0 || !rw) |-> sda_dev_oe && !sda;
   endproperty
   a_dev_ack: assert property (p_dev_ack) else $error("device ack missing");
   property p_host_nack; hi_c && pos == 4'h9 && byte_idx == 3'h1 && rw |-> sda; endproperty
   a_host_nack: assert property (p_host_nack) else $error("read byte not closed");
   property p_no_contend;
      hi_c && pos != 4'h9 && !(rw && byte_idx == 3'h1) |-> !sda_dev_oe;
   endproperty
   a_no_contend: assert property (p_no_contend) else $error("device drives host bit");
   property p_dev_hold; hi_c |-> $stable(sda_dev_oe); endproperty
   a_dev_hold: assert property (p_dev_hold) else $error("device sda moved in high");
   property p_quiet_idle; !in_frame |-> !sda_dev_oe; endproperty
   a_quiet_idle: assert property (p_quiet_idle) else $error("device drives outside frame");
   property p_host_yield;
      hi_c && pos == 4'h9 && (byte_idx == 3'h0 || !rw) |-> !sda_host_oe;
   endproperty
   a_host_yield: assert property (p_host_yield) else $error("host drives device ack");
   property p_idle_free; !in_frame |-> !scl_host_oe; endproperty
   a_idle_free: assert property (p_idle_free) else $error("clock held outside frame");
   property p_scl_alive; in_frame && $fell(scl) |-> ##[1:40] scl; endproperty
   a_scl_alive: assert property (p_scl_alive) else $error("serial clock stalled");
   c_write_data: cover property (hi_c && pos == 4'h9 && byte_idx == 3'h2 && !rw);
   c_read_data: cover property (hi_c && pos == 4'h8 && byte_idx == 3'h1 && rw);
   c_stop: cover property (stop_c);
endmodule

//--- dv/tb_clock_synth_serial_config_port.sv
`timescale 1ns/1ps
module tb_clock_synth_serial_config_port;
   import clk_cfg_pkg::*;
   typedef struct {logic [4:0] idx; logic [7:0] data; logic [7:0] rb;} row_s;
   logic        ref_clk_in, reset_n_in, wr_in, rd_in, cpu_stop_n_in;
   logic [1:0]  addr_in;
   logic [15:0] wdata_in, rdata_out;
   logic [4:0]  strap_freq_pins_in, freq_select_out;
   logic [2:0]  spread_mode_out;
   logic        spread_reserved_out, chipset_cpu_pair_en_out, cpu_pair_one_en_out;
   logic        cpu_pair_zero_en_out, chipset_pair_free_en_out;
   logic [7:0]  m0, m1, got;
   int          failures, checked;
   row_s rows[10] = '{'{5'h01, 8'h00, 8'h00}, '{5'h01, 8'h4E, 8'h4E}, '{5'h01, 8'h51, 8'h51},
      '{5'h01, 8'h62, 8'h62}, '{5'h01, 8'h7F, 8'h7F}, '{5'h01, 8'h14, 8'h14},
      '{5'h01, 8'h3A, 8'h3A}, '{5'h00, 8'h78, 8'h78}, '{5'h00, 8'h06, 8'h06},
      '{5'h02, 8'hA5, 8'h00}};
   cfg_link_if link_if ();
   clk_cfg_host #(.HALF(8)) clk_cfg_host_inst (.ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out), .link(link_if));
   clk_cfg_dev clk_cfg_dev_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .link(link_if), .strap_freq_pins_in(strap_freq_pins_in),
      .cpu_stop_n_in(cpu_stop_n_in), .freq_select_out(freq_select_out),
      .spread_mode_out(spread_mode_out), .spread_reserved_out(spread_reserved_out),
      .chipset_cpu_pair_en_out(chipset_cpu_pair_en_out),
      .cpu_pair_one_en_out(cpu_pair_one_en_out), .cpu_pair_zero_en_out(cpu_pair_zero_en_out),
      .chipset_pair_free_en_out(chipset_pair_free_en_out));
   clk_cfg_link_checker clk_cfg_link_checker_inst (.ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in), .scl_host_oe(link_if.scl_host_oe),
      .sda_host_oe(link_if.sda_host_oe), .sda_dev_oe(link_if.sda_dev_oe),
      .scl(link_if.scl), .sda(link_if.sda));
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask
   // read data appear in the cycle after the strobe and hold until the next strobe
   task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge ref_clk_in);
      addr_in <= a; rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      @(negedge ref_clk_in);
      d = rdata_out;
   endtask
   // bounded poll, so a stuck busy flag shows as a mismatch, not a hang
   task automatic wait_idle();
      logic [15:0] st;
      int n;
      st = 16'h0001; n = 0;
      while (st[0] !== 1'b0 && n < 4000) begin bus_rd(2'h1, st); n++; end
      chk("busy", 8'h00, 8'(st[0]));
      chk("nack", 8'h00, 8'(st[1]));
   endtask
   task automatic xfer(input logic rd, input logic [4:0] idx, input logic [7:0] d);
      logic [15:0] st;
      wait_idle();
      bus_wr(2'h0, {rd, 2'h0, idx, d});
      wait_idle();
      bus_rd(2'h2, st);
      got = st[7:0];
   endtask
   // outputs against the byte model, for two straps and both stop levels
   task automatic check_outs();
      logic [4:0] sp;
      for (int k = 0; k < 4; k++) begin
         sp = k[0] ? 5'h13 : 5'h0C;
         @(posedge ref_clk_in);
         strap_freq_pins_in <= sp; cpu_stop_n_in <= k[1];
         repeat (3) @(posedge ref_clk_in);
         chk("freq", 8'(m0[3] ? {m0[2:1], m0[6:4]} : sp), 8'(freq_select_out));
         chk("spread", 8'(m1[6:4]), 8'(spread_mode_out));
         chk("reserved", 8'(m1[6:4] != 3'h0 && !m1[6]), 8'(spread_reserved_out));
         chk("enables", 8'(m1[3:1]), 8'({chipset_cpu_pair_en_out, cpu_pair_one_en_out,
            cpu_pair_zero_en_out}));
         chk("free", 8'(m1[0] | k[1]), 8'(chipset_pair_free_en_out));
      end
   endtask
   // ************************************************************
   // clock, watchdog, main sequence
   // ************************************************************
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      repeat (90000) @(posedge ref_clk_in);
      failures++;
      print_verdict();
   end
   initial begin
      failures = 0; checked = 0; reset_n_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0;
      addr_in = 2'h0; wdata_in = 16'h0000; strap_freq_pins_in = 5'h13; cpu_stop_n_in = 1'b1;
      repeat (5) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      m0 = 8'h00; m1 = 8'h0F;
      check_outs();
      $display("defaults done");
      foreach (rows[i]) begin
         xfer(1'b0, rows[i].idx, rows[i].data);
         xfer(1'b1, rows[i].idx, 8'h00);
         chk("readback", rows[i].rb, got);
         if (rows[i].idx == 5'h00) m0 = rows[i].data;
         if (rows[i].idx == 5'h01) m1 = rows[i].data;
         check_outs();
         $display("row %0d done", i);
      end
      // second command while busy must be dropped
      bus_wr(2'h0, {1'b0, 2'h0, 5'h00, 8'h0E});
      bus_wr(2'h0, {1'b0, 2'h0, 5'h00, 8'h78});
      xfer(1'b1, 5'h00, 8'h00);
      chk("refused", 8'h0E, got);
      m0 = 8'h0E;
      check_outs();
      $display("busy refusal done");
      // reset in mid-run restores defaults
      @(posedge ref_clk_in);
      reset_n_in <= 1'b0;
      repeat (5) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      m0 = 8'h00; m1 = 8'h0F;
      check_outs();
      xfer(1'b1, 5'h01, 8'h00);
      chk("reset byte1", 8'h0F, got);
      $display("mid reset done");
      print_verdict();
   end
endmodule
